// File: logic/bvm_pkg.sv
// Constants for the block value and clock group MODBUS command engine.
// Assumes frames arrive already address-filtered and CRC-checked.
package bvm_pkg;
    // ------------------------------------------------------------
    // Function codes and exception codes
    // ------------------------------------------------------------
    localparam logic [7:0] FC_RD_HOLD = 8'h03;
    localparam logic [7:0] FC_CLK_RD = 8'h41;
    localparam logic [7:0] FC_CLK_WR = 8'h42;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_DATA = 8'h03;
    // ------------------------------------------------------------
    // Address regions and strides
    // ------------------------------------------------------------
    localparam logic [15:0] RUN_BASE = 16'hC000;
    localparam logic [15:0] PAR_BASE = 16'h8000;
    localparam int BLK_SHIFT = 5;
    localparam int PAR_SHIFT = 2;
    localparam int CLK_BLK_SHIFT = 8;
    localparam int CLK_GRP_SHIFT = 3;
    // ------------------------------------------------------------
    // Quantities, byte counts, frame lengths
    // ------------------------------------------------------------
    localparam logic [15:0] RUN_QTY = 16'h0002;
    localparam logic [7:0] RUN_BYTES = 8'h04;
    localparam logic [15:0] CLK_QTY = 16'h0004;
    localparam logic [7:0] CLK_BYTES = 8'h08;
    localparam logic [3:0] HDR_LEN = 4'h5;
    localparam logic [3:0] WR_LEN = 4'hE;
    localparam logic [3:0] RUN_RSP_LEN = 4'h6;
    localparam logic [3:0] CLK_RSP_LEN = 4'hA;
    localparam logic [3:0] EXC_RSP_LEN = 4'h2;
    // ------------------------------------------------------------
    // Clock record layout (byte index, 7 = first on the wire)
    // ------------------------------------------------------------
    localparam int REC_STATE = 7;
    localparam int REC_MODE = 6;
    localparam int REC_YEAR = 5;
    localparam logic [7:0] STATE_OFF = 8'h00;
    localparam logic [7:0] STATE_ON = 8'h01;
    localparam logic [7:0] MODE_FIRST = 8'h01;
    localparam logic [7:0] MODE_LAST = 8'h10;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [63:0] REC_RESET = 64'h0;
endpackage

// File: logic/bvm_clk_store.sv
// Clock time group store: one 8-byte record per block and group.
// Assumes one clock and a reset already synchronised by the caller.
`timescale 1ns/1ps
module bvm_clk_store #(
    parameter int NBLK = 16,
    parameter int NGRP = 8,
    parameter int IW = $clog2(NBLK * NGRP)
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [IW-1:0] rd_idx,
    output logic [63:0] rd_rec,
    output logic rd_exist,
    input wire logic wr_en,
    input wire logic [63:0] wr_rec,
    input wire logic app_wr,
    input wire logic app_del,
    input wire logic [IW-1:0] app_idx,
    input wire logic [63:0] app_rec
);
    import bvm_pkg::*;
    localparam int DEPTH = NBLK * NGRP;

    typedef struct packed {
        logic [DEPTH-1:0] exist;
        logic [63:0] rd_rec;
        logic rd_exist;
    } bvm_store_t;

    bvm_store_t cur;
    bvm_store_t next_cur;
    logic [63:0] mem [DEPTH];

    // ------------------------------------------------------------
    // Existence flags; only the application creates or drops groups
    // ------------------------------------------------------------
    always_comb
    begin
        next_cur = cur;
        next_cur.rd_rec = mem[rd_idx];
        next_cur.rd_exist = cur.exist[rd_idx];
        if (app_wr)
            next_cur.exist[app_idx] = 1'b1;
        else if (app_del)
            next_cur.exist[app_idx] = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            cur <= '0;
        else
            cur <= next_cur;
    end

    // Record storage; remote write only lands on a live group
    always_ff @(posedge clk_sys)
    begin
        if (app_wr)
            mem[app_idx] <= app_rec;
        else if (wr_en && cur.exist[rd_idx])
            mem[rd_idx] <= wr_rec;
    end

    assign rd_rec = cur.rd_rec;
    assign rd_exist = cur.rd_exist;
endmodule

// File: logic/bvm_core.sv
// MODBUS command engine for running values and clock time groups.
// Assumes request PDU bytes (function code first, no slave address,
// no CRC) and a response sink that frames and checksums the reply.
`timescale 1ns/1ps
module bvm_core #(
    parameter int NBLK = 16,
    parameter int NGRP = 8,
    parameter int IW = $clog2(NBLK * NGRP)
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    input wire logic rx_end,
    output logic busy,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready,
    output logic val_rd,
    output logic val_region,
    output logic [8:0] val_blk,
    output logic [2:0] val_par,
    input wire logic [31:0] val_data,
    input wire logic app_wr,
    input wire logic app_del,
    input wire logic [IW-1:0] app_idx,
    input wire logic [63:0] app_rec
);
    import bvm_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_EXEC = 4'b0010,
        ST_FETCH = 4'b0100,
        ST_SEND = 4'b1000
    } bvm_st_t;

    typedef enum logic [1:0] {
        K_RUN = 2'h0,
        K_CKR = 2'h1,
        K_CKW = 2'h2
    } bvm_kind_t;

    typedef struct packed {
        bvm_st_t st;
        bvm_kind_t kind;
        logic [3:0] rq_n;
        logic ovf;
        logic [13:0][7:0] rq;
        logic [9:0][7:0] rsp;
        logic [3:0] rsp_n;
        logic [3:0] tx_i;
        logic [7:0] tx_data;
        logic tx_valid;
        logic tx_last;
        logic busy;
        logic val_rd;
        logic val_region;
        logic [8:0] val_blk;
        logic [2:0] val_par;
        logic [IW-1:0] ck_idx;
        logic ck_wr;
    } bvm_core_t;

    bvm_core_t cur;
    bvm_core_t next_cur;
    logic [1:0] rst_q;
    logic rst_n;
    logic [63:0] rd_rec;
    logic rd_exist;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [63:0] wr_rec;

    // ------------------------------------------------------------
    // Reset release through two flip-flops
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            rst_q <= 2'h0;
        else
            rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_n = rst_q[1];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Group index from clock address; groups start every eight words
    function automatic logic [IW-1:0] clk_index(input logic [15:0] a);
        logic [31:0] i;
        i = 32'(a >> CLK_BLK_SHIFT) * 32'(NGRP)
            + 32'(a[CLK_BLK_SHIFT-1:CLK_GRP_SHIFT]);
        return i[IW-1:0];
    endfunction

    // Date and time bytes must hold two decimal digits each
    function automatic logic rec_ok(input logic [63:0] r);
        logic ok;
        ok = (r[REC_STATE*8 +: 8] == STATE_ON)
            || (r[REC_STATE*8 +: 8] == STATE_OFF);
        ok = ok && (r[REC_MODE*8 +: 8] >= MODE_FIRST)
            && (r[REC_MODE*8 +: 8] <= MODE_LAST);
        for (int b = 0; b <= REC_YEAR; b++)
            ok = ok && (r[b*8+4 +: 4] <= BCD_MAX)
                && (r[b*8 +: 4] <= BCD_MAX);
        return ok;
    endfunction

    assign addr = {cur.rq[1], cur.rq[2]};
    assign qty = {cur.rq[3], cur.rq[4]};
    // Wire order is state, mode, year ... second, first byte on top
    assign wr_rec = {cur.rq[6], cur.rq[7], cur.rq[8], cur.rq[9],
        cur.rq[10], cur.rq[11], cur.rq[12], cur.rq[13]};

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_cur = cur;
        next_cur.val_rd = 1'b0;
        next_cur.ck_wr = 1'b0;
        unique case (cur.st)
            ST_IDLE:
            begin
                // Bytes beyond the longest request mark the frame bad
                if (rx_valid)
                begin
                    if (cur.rq_n < WR_LEN)
                    begin
                        next_cur.rq[cur.rq_n] = rx_byte;
                        next_cur.rq_n = cur.rq_n + 4'h1;
                    end
                    else
                        next_cur.ovf = 1'b1;
                end
                if (rx_end)
                begin
                    next_cur.st = ST_EXEC;
                    next_cur.busy = 1'b1;
                end
            end
            ST_EXEC:
            begin
                next_cur.st = ST_SEND;
                next_cur.rsp_n = EXC_RSP_LEN;
                next_cur.rsp[0] = cur.rq[0] | EXC_FLAG;
                next_cur.rsp[1] = EXC_DATA;
                if (cur.ovf || cur.rq_n < HDR_LEN)
                    next_cur.rsp[1] = EXC_DATA;
                else if (cur.rq[0] == FC_RD_HOLD)
                begin
                    // Parameter region below, running values above
                    if (addr < PAR_BASE || addr[1:0] != 2'h0)
                        next_cur.rsp[1] = EXC_ADDR;
                    else if (qty != RUN_QTY || cur.rq_n != HDR_LEN)
                        next_cur.rsp[1] = EXC_DATA;
                    else
                    begin
                        next_cur.st = ST_FETCH;
                        next_cur.kind = K_RUN;
                        next_cur.val_rd = 1'b1;
                        next_cur.val_region = addr >= RUN_BASE;
                        next_cur.val_blk = addr[13:BLK_SHIFT];
                        next_cur.val_par = addr[BLK_SHIFT-1:PAR_SHIFT];
                    end
                end
                else if (cur.rq[0] == FC_CLK_RD || cur.rq[0] == FC_CLK_WR)
                begin
                    if (addr[CLK_GRP_SHIFT-1:0] != 3'h0
                        || 32'(addr >> CLK_BLK_SHIFT) >= NBLK
                        || 32'(addr[7:CLK_GRP_SHIFT]) >= NGRP)
                        next_cur.rsp[1] = EXC_ADDR;
                    else if (qty != CLK_QTY)
                        next_cur.rsp[1] = EXC_DATA;
                    else if (cur.rq[0] == FC_CLK_WR
                        && (cur.rq_n != WR_LEN || cur.rq[5] != CLK_BYTES))
                        next_cur.rsp[1] = EXC_DATA;
                    else if (cur.rq[0] == FC_CLK_RD && cur.rq_n != HDR_LEN)
                        next_cur.rsp[1] = EXC_DATA;
                    else
                    begin
                        next_cur.st = ST_FETCH;
                        next_cur.kind = (cur.rq[0] == FC_CLK_RD)
                            ? K_CKR : K_CKW;
                        next_cur.ck_idx = clk_index(addr);
                    end
                end
                else
                    next_cur.rsp[1] = EXC_FUNC;
            end
            ST_FETCH:
            begin
                next_cur.st = ST_SEND;
                next_cur.rsp_n = EXC_RSP_LEN;
                next_cur.rsp[0] = cur.rq[0] | EXC_FLAG;
                next_cur.rsp[1] = EXC_ADDR;
                unique case (cur.kind)
                    K_RUN:
                    begin
                        // Value already scaled by its source
                        next_cur.rsp_n = RUN_RSP_LEN;
                        next_cur.rsp[0] = cur.rq[0];
                        next_cur.rsp[1] = RUN_BYTES;
                        for (int b = 0; b < 4; b++)
                            next_cur.rsp[2+b] = val_data[31-8*b -: 8];
                    end
                    K_CKR:
                    begin
                        if (rd_exist)
                        begin
                            next_cur.rsp_n = CLK_RSP_LEN;
                            next_cur.rsp[0] = cur.rq[0];
                            next_cur.rsp[1] = CLK_BYTES;
                            for (int b = 0; b < 8; b++)
                                next_cur.rsp[2+b] = rd_rec[63-8*b -: 8];
                        end
                    end
                    default:
                    begin
                        if (!rd_exist)
                            next_cur.rsp[1] = EXC_ADDR;
                        else if (!rec_ok(wr_rec))
                            next_cur.rsp[1] = EXC_DATA;
                        else
                        begin
                            next_cur.ck_wr = 1'b1;
                            next_cur.rsp_n = HDR_LEN;
                            for (int b = 0; b < 5; b++)
                                next_cur.rsp[b] = cur.rq[b];
                        end
                    end
                endcase
            end
            ST_SEND:
            begin
                // Holds each byte until the sink takes it
                if (!cur.tx_valid || tx_ready)
                begin
                    if (cur.tx_valid && cur.tx_last)
                    begin
                        next_cur.tx_valid = 1'b0;
                        next_cur.tx_last = 1'b0;
                        next_cur.tx_i = 4'h0;
                        next_cur.rq_n = 4'h0;
                        next_cur.ovf = 1'b0;
                        next_cur.busy = 1'b0;
                        next_cur.st = ST_IDLE;
                    end
                    else
                    begin
                        next_cur.tx_valid = 1'b1;
                        next_cur.tx_data = cur.rsp[cur.tx_i];
                        next_cur.tx_last = cur.tx_i == cur.rsp_n - 4'h1;
                        next_cur.tx_i = cur.tx_i + 4'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur <= '0;
            cur.st <= ST_IDLE;
        end
        else
            cur <= next_cur;
    end

    // ------------------------------------------------------------
    // Clock group store
    // ------------------------------------------------------------
    bvm_clk_store #(
        .NBLK(NBLK),
        .NGRP(NGRP),
        .IW(IW)
    ) u_store (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        // Next index, so the registered read is ready in fetch
        .rd_idx(next_cur.ck_idx),
        .rd_rec(rd_rec),
        .rd_exist(rd_exist),
        .wr_en(cur.ck_wr),
        .wr_rec(wr_rec),
        .app_wr(app_wr),
        .app_del(app_del),
        .app_idx(app_idx),
        .app_rec(app_rec)
    );

    assign busy = cur.busy;
    assign tx_data = cur.tx_data;
    assign tx_valid = cur.tx_valid;
    assign tx_last = cur.tx_last;
    assign val_rd = cur.val_rd;
    assign val_region = cur.val_region;
    assign val_blk = cur.val_blk;
    assign val_par = cur.val_par;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_run_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(val_rd) |-> val_blk == $past(addr[13:5])
            && val_region == ($past(addr) >= 16'hC000))
        else $error("running value address decode wrong");
    a_run_bytes: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cur.st == ST_FETCH && cur.kind == K_RUN |=> cur.rsp_n == 4'h6
            && cur.rsp[1] == 8'h04 && cur.rsp[5] == $past(val_data[7:0]))
        else $error("running value reply malformed");
    a_clk_rd_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cur.st == ST_FETCH && cur.kind == K_CKR && rd_exist |=>
            cur.rsp_n == 4'hA && cur.rsp[1] == 8'h08
            && cur.rsp[2] == $past(rd_rec[63:56]))
        else $error("clock read reply malformed");
    a_clk_echo: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cur.ck_wr |-> cur.rsp_n == 4'h5 && cur.rsp[0] == 8'h42
            && cur.rsp[4] == 8'h04)
        else $error("clock write echo wrong");
    a_clk_index: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cur.st == ST_FETCH && cur.kind != K_RUN |->
            32'(cur.ck_idx) == 32'(addr[15:8]) * NGRP + 32'(addr[7:3]))
        else $error("clock group index wrong");
    a_no_create: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cur.ck_wr |-> $past(rd_exist))
        else $error("write to a missing group");
    a_rec_fields: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cur.ck_wr |-> wr_rec[63:56] <= 8'h01 && wr_rec[55:48] != 8'h00
            && wr_rec[55:48] <= 8'h10)
        else $error("bad state or mode written");
    a_exc_reply: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cur.st == ST_EXEC && cur.rq[0] == 8'h41 && cur.rq_n == 4'h5
            && addr[2:0] == 3'h0 && 32'(addr[15:8]) < NBLK
            && 32'(addr[7:3]) < NGRP
            && qty != 16'h0004 |=> cur.st == ST_SEND
            && cur.rsp[0] == 8'hC1 && cur.rsp[1] == 8'h03 ##1 tx_valid)
        else $error("bad quantity not refused");
endmodule

// File: test/bvm_master.sv
// Request master model for the command engine's PDU ports.
// Assumes the engine's byte handshakes; drives only at falling edges.
`timescale 1ns/1ps
module bvm_master (
    input wire logic clk_sys,
    input wire logic busy,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic rx_end,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready
);
    // Percent of cycles in which the reply sink stalls
    int stall = 0;

    // Idle levels at time zero
    initial
    begin
        rx_byte = 8'hA5;
        rx_valid = 1'b0;
        rx_end = 1'b0;
        tx_ready = 1'b0;
    end

    // ------------------------------------------------------------
    // One request out, one reply in
    // ------------------------------------------------------------
    // Caller frames quantity, byte count and record order
    task automatic xfer(input logic [7:0] req [$],
                        output logic [7:0] rsp [$], output bit ok);
        int n;
        rsp = {};
        ok = 1'b0;
        n = 0;
        // Engine ignores bytes while busy, so wait it out
        while (busy !== 1'b0 && n < 100)
        begin
            @(negedge clk_sys);
            n++;
        end
        foreach (req[i])
        begin
            @(negedge clk_sys);
            rx_byte = req[i];
            rx_valid = 1'b1;
        end
        @(negedge clk_sys);
        rx_byte = ~rx_byte; // Released line shows no stale byte
        rx_valid = 1'b0;
        rx_end = 1'b1;
        @(negedge clk_sys);
        rx_end = 1'b0;
        // Sink is no kinder than a slow panel: random stalls
        // Byte is looked at mid-cycle, where it is settled; the
        // engine takes it at the next rising edge
        for (n = 0; n < 400 && !ok; n++)
        begin
            tx_ready = ($urandom % 100) >= stall;
            if (tx_valid === 1'b1 && tx_ready)
            begin
                rsp.push_back(tx_data);
                ok = (tx_last === 1'b1);
            end
            @(negedge clk_sys);
        end
        tx_ready = 1'b0;
    endtask
endmodule

// File: test/bvm_core_tb_top.sv
// Self-checking bench for the command engine, master model and value source.
// Assumes the engine's ports as handed over; one 10 MHz clock.
`timescale 1ns/1ps
module bvm_core_tb_top;
    import bvm_pkg::*;
    localparam int NBLK = 16;
    localparam int NGRP = 8;
    localparam int IW = 7;
    localparam int NREC = NBLK * NGRP;
    logic clk_sys, arst_n, rx_valid, rx_end, busy, tx_valid, tx_last;
    logic tx_ready, val_rd, val_region, app_wr, app_del;
    logic [7:0] rx_byte, tx_data;
    logic [8:0] val_blk;
    logic [2:0] val_par;
    logic [31:0] val_data;
    logic [IW-1:0] app_idx;
    logic [63:0] app_rec;
    logic [63:0] recs [NREC];
    bit live [NREC];
    int errors = 0;
    int cmp_count = 0;

    // ------------------------------------------------------------
    // Clock, value source, instances
    // ------------------------------------------------------------
    // Free running system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Source values are already scaled; two known corner values
    function automatic logic [31:0] val_of(logic rg, logic [8:0] b,
                                           logic [2:0] p);
        if (rg && b == 9'h005 && p == 3'h0) return 32'h000004B1;
        if (rg && b == 9'h001 && p == 3'h0) return 32'h00005FFA;
        return {7'h00, rg, 7'h00, b, 5'h00, p};
    endfunction
    assign val_data = val_of(val_region, val_blk, val_par);

    bvm_master m (.clk_sys(clk_sys), .busy(busy), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .rx_end(rx_end), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));

    bvm_core #(.NBLK(NBLK), .NGRP(NGRP), .IW(IW)) dut (.clk_sys(clk_sys),
        .arst_n(arst_n), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .rx_end(rx_end), .busy(busy), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
        .val_rd(val_rd), .val_region(val_region), .val_blk(val_blk),
        .val_par(val_par), .val_data(val_data), .app_wr(app_wr),
        .app_del(app_del), .app_idx(app_idx), .app_rec(app_rec));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Appends n bytes of v, most significant first
    function automatic void put(ref logic [7:0] q [$], input logic [63:0] v,
                                input int n);
        for (int i = n - 1; i >= 0; i--) q.push_back(v[i*8+:8]);
    endfunction

    function automatic bit rec_ok(logic [63:0] r);
        bit ok;
        ok = r[63:56] <= STATE_ON;
        ok &= r[55:48] >= MODE_FIRST && r[55:48] <= MODE_LAST;
        for (int i = 0; i < 12; i++) ok &= r[i*4+:4] <= BCD_MAX;
        return ok;
    endfunction

    function automatic logic [63:0] rnd_rec();
        logic [63:0] r;
        r[63:56] = 8'($urandom % 2);
        r[55:48] = 8'(1 + $urandom % 16);
        for (int i = 0; i < 12; i++) r[i*4+:4] = 4'($urandom % 10);
        return r;
    endfunction

    task automatic xact(input logic [7:0] req [$], input logic [7:0] exp [$]);
        logic [7:0] rsp [$];
        bit ok;
        m.xfer(req, rsp, ok);
        check(64'(ok), 64'h1);
        check(64'(busy), 64'h0);
        check(64'(rsp.size()), 64'(exp.size()));
        foreach (exp[i]) check(64'(rsp[i]), 64'(exp[i]));
    endtask

    task automatic run_rd(logic [15:0] a, logic [31:0] v);
        logic [7:0] e [$];
        e = {FC_RD_HOLD, RUN_BYTES};
        put(e, 64'(v), 4);
        xact({FC_RD_HOLD, a[15:8], a[7:0], 8'h00, 8'h02}, e);
    endtask

    task automatic clk_rd(int b, int g);
        logic [7:0] e [$];
        logic [15:0] a;
        a = 16'(b * 256 + g * 8);
        e = {FC_CLK_RD, CLK_BYTES};
        put(e, recs[b * NGRP + g], 8);
        if (!live[b * NGRP + g])
            e = {FC_CLK_RD | EXC_FLAG, EXC_ADDR};
        xact({FC_CLK_RD, a[15:8], a[7:0], 8'h00, 8'h04}, e);
    endtask

    task automatic clk_wr(int b, int g, logic [63:0] r);
        logic [7:0] q [$];
        logic [7:0] e [$];
        logic [15:0] a;
        int k;
        k = b * NGRP + g;
        a = 16'(b * 256 + g * 8);
        q = {FC_CLK_WR, a[15:8], a[7:0], 8'h00, 8'h04, CLK_BYTES};
        put(q, r, 8);
        e = {FC_CLK_WR, a[15:8], a[7:0], 8'h00, 8'h04};
        if (!live[k])
            e = {FC_CLK_WR | EXC_FLAG, EXC_ADDR};
        else if (!rec_ok(r))
            e = {FC_CLK_WR | EXC_FLAG, EXC_DATA};
        else
            recs[k] = r;
        xact(q, e);
    endtask

    task automatic app_put(int k, logic [63:0] r, bit del);
        @(negedge clk_sys);
        app_idx = IW'(k);
        app_rec = r;
        app_wr = !del;
        app_del = del;
        @(negedge clk_sys);
        app_wr = 1'b0;
        app_del = 1'b0;
        live[k] = !del;
        if (!del)
            recs[k] = r;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    // Watchdog sized well past the expected run of some 3k cycles
    initial
    begin
        repeat (80000) @(posedge clk_sys);
        errors++;
        summarize();
    end

    // Main sequence
    initial
    begin
        int b;
        int p;
        int k;
        logic rg;
        void'($urandom(32'h6DEB));
        arst_n = 1'b0;
        app_wr = 1'b0;
        app_del = 1'b0;
        app_idx = '0;
        app_rec = '0;
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        run_rd(16'hC0A0, 32'h000004B1);
        run_rd(16'hC020, 32'h00005FFA);
        for (int i = 0; i < 24; i++)
        begin
            b = (i == 0) ? 511 : $urandom % 512;
            p = $urandom % 8;
            rg = 1'($urandom % 2);
            m.stall = $urandom % 60;
            run_rd(16'((rg ? 32'hC000 : 32'h8000) + b * 32 + p * 4),
                   val_of(rg, 9'(b), 3'(p)));
        end
        xact({FC_RD_HOLD, 8'hC0, 8'hA0, 8'h00, 8'h03},
             {8'h83, EXC_DATA});
        xact({FC_RD_HOLD, 8'h80, 8'h02, 8'h00, 8'h02},
             {8'h83, EXC_ADDR});
        xact({8'h10, 8'h80, 8'h00, 8'h00, 8'h02}, {8'h90, EXC_FUNC});
        xact({FC_CLK_RD, 8'h00, 8'h00, 8'h00, 8'h03},
             {8'hC1, EXC_DATA});
        xact({FC_CLK_RD, 8'h10, 8'h00, 8'h00, 8'h04},
             {8'hC1, EXC_ADDR});
        app_put(0, 64'h0101091208170521, 1'b0);
        clk_rd(0, 0);
        app_put(2 * NGRP + 1, 64'h0004090716143532, 1'b0);
        clk_wr(2, 1, 64'h0104090730080859);
        clk_rd(2, 1);
        clk_wr(3, 2, 64'h0104090730080859);
        clk_rd(3, 2);
        clk_wr(0, 0, 64'h0201091208170521);
        clk_wr(0, 0, 64'h010109120A170521);
        for (int md = 0; md < 18; md++)
        begin
            clk_wr(0, 0, {8'h01, 8'(md), 48'h091208170521});
            clk_rd(0, 0);
        end
        app_put(0, 64'h0, 1'b1);
        clk_rd(0, 0);
        for (int i = 0; i < 40; i++)
        begin
            k = $urandom % NREC;
            m.stall = $urandom % 60;
            if ($urandom % 3 == 0)
                app_put(k, rnd_rec(), 1'($urandom % 4 == 0));
            clk_wr(k / NGRP, k % NGRP,
                   rnd_rec() ^ {($urandom % 5 == 0), 63'h0});
            clk_rd(k / NGRP, k % NGRP);
        end
        summarize();
    end
endmodule
